//--- mdio_master.sv
// management master model that clocks frames onto the serial pins
`timescale 1ns/1ns
`default_nettype none
module mdio_master (
    // device side of the data pin
    input wire mdio_oe_n,
    input wire mdio_out,
    // pins seen by the device
    output reg mdc,
    output wire mdio
);
    reg drv = 1'b0;
    reg bit_o = 1'b1;
    initial mdc = 1'b0;
    // a released line floats up to the pull-up level
    assign mdio = !mdio_oe_n ? mdio_out : (drv ? bit_o : 1'b1);
    // mdc stands low between frames; master data moves only while mdc is low
    task automatic xfer(input [1:0] op, input [4:0] pa, input [4:0] ra,
        input [15:0] wd, output [15:0] rd);
        reg [63:0] f;
        integer i;
    begin
        // 1 ns lead and 9 ns tail keep frames on the clk grid, off every clk edge
        #1;
        f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (i = 63; i >= 0; i = i - 1)
        begin
            drv = (op == 2'b01) || (i > 17);
            bit_o = f[i];
            #62;
            mdc = 1'b1;
            if (i < 16) rd = {rd[14:0], mdio};
            #63;
            mdc = 1'b0;
        end
        drv = 1'b0;
        #9;
    end
    endtask
endmodule // mdio_master
`default_nettype wire

//--- phy_basic_control_register.v
// basic control register with serial management slave
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_defines.vh"
module phy_basic_control_register #(
    parameter [5:0] PRE_LEN = `PREAMBLE_ONES
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // management pins
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n,
    // straps and pins
    input wire [4:0] phy_address,
    input wire [2:0] ability_straps,
    input wire autoneg_allowed_strap,
    input wire hiz_default_strap,
    input wire low_power_pin,
    input wire isolate_pin,
    // control outputs
    output reg device_reset,
    output reg digital_loopback,
    output reg medium_tx_off,
    output reg medium_rx_off,
    output reg manual_mode,
    output reg manual_speed_100,
    output reg autoneg_run,
    output reg autoneg_kick,
    output reg low_power,
    output reg mii_hiz
);
    // frame slave states
    localparam ST_PRE = 3'h0;
    localparam ST_HDR = 3'h1;
    localparam ST_TA = 3'h2;
    localparam ST_RD = 3'h3;
    localparam ST_WR = 3'h4;

    reg [13:0] sync1;
    reg [13:0] sync2;
    reg mdc_prev;
    reg [2:0] state;
    reg [5:0] cnt;
    reg [11:0] hdr;
    reg [15:0] rd_sh;
    reg [15:0] wr_sh;
    reg is_read;
    reg hit;
    reg wr_go;
    reg [15:0] wr_data;
    reg [2:0] init_cnt;
    reg speed_select_100;
    reg autoneg_enable;
    reg low_power_request;
    reg isolate_bit;

    wire s_mdc = sync2[13];
    wire s_mdio = sync2[12];
    wire [4:0] s_phy = sync2[11:7];
    wire [2:0] s_abil = sync2[6:4];
    wire s_an_allowed = sync2[3];
    wire s_hiz_def = sync2[2];
    wire s_lp_pin = sync2[1];
    wire s_iso_pin = sync2[0];
    // mdc passes the same two stages as data, so each bit lines up with its edge
    wire rise = s_mdc & ~mdc_prev;
    wire init_busy = (init_cnt != 3'h0);
    wire only_10 = s_abil[`ABIL_10] & ~s_abil[`ABIL_100];
    wire only_100 = s_abil[`ABIL_100] & ~s_abil[`ABIL_10];
    wire [12:0] full = {hdr, s_mdio};
    wire frame_ok = full[12] & ((full[11:10] == `OP_READ) | (full[11:10] == `OP_WRITE));
    wire addr_hit = ((full[9:5] == s_phy) | (full[9:5] == `BCAST_PHY_ADDR))
        & (full[4:0] == `CTRL_REG_ADDR);
    // self-clearing bits read back zero; reset bit shows one while defaults reload
    wire [15:0] readback = {init_busy, digital_loopback, speed_select_100,
        autoneg_enable, low_power_request, isolate_bit, 1'b0, 9'h000};

    // every pin passes two flops; the first stage feeds only the second
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1 <= 14'h0000;
            sync2 <= 14'h0000;
            mdc_prev <= 1'b0;
        end
        else
        begin
            sync1 <= {mdc, mdio_in, phy_address, ability_straps, autoneg_allowed_strap,
                hiz_default_strap, low_power_pin, isolate_pin};
            sync2 <= sync1;
            mdc_prev <= s_mdc;
        end
    end

    // management frame slave, sampled on rising management clock
    always @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_PRE;
            cnt <= 6'h00;
            hdr <= 12'h000;
            rd_sh <= 16'h0000;
            wr_sh <= 16'h0000;
            is_read <= 1'b0;
            hit <= 1'b0;
            wr_go <= 1'b0;
            wr_data <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe_n <= 1'b1;
        end
        else
        begin
            wr_go <= 1'b0;
            if (rise)
            begin
                case (state)
                    ST_PRE:
                    begin
                        if (s_mdio)
                        begin
                            // saturate so a long idle line never wraps the count
                            if (cnt != 6'h3f)
                                cnt <= cnt + 6'h01;
                        end
                        else if (cnt >= PRE_LEN)
                        begin
                            state <= ST_HDR;
                            cnt <= 6'h00;
                        end
                        else
                            cnt <= 6'h00;
                    end
                    ST_HDR:
                    begin
                        hdr <= full[11:0];
                        cnt <= cnt + 6'h01;
                        if (cnt == 6'h0c)
                        begin
                            cnt <= 6'h00;
                            is_read <= (full[11:10] == `OP_READ);
                            hit <= addr_hit;
                            rd_sh <= readback;
                            // other registers and bad frames leave the pin released
                            state <= frame_ok ? ST_TA : ST_PRE;
                        end
                    end
                    ST_TA:
                    begin
                        cnt <= cnt + 6'h01;
                        // drive low through the second turnaround bit, then shift data
                        if (cnt == 6'h00)
                        begin
                            if (is_read & hit)
                            begin
                                mdio_oe_n <= 1'b0;
                                mdio_out <= 1'b0;
                            end
                        end
                        else
                        begin
                            cnt <= 6'h00;
                            state <= is_read ? ST_RD : ST_WR;
                            if (is_read & hit)
                            begin
                                mdio_out <= rd_sh[15];
                                rd_sh <= {rd_sh[14:0], 1'b0};
                            end
                        end
                    end
                    ST_RD:
                    begin
                        cnt <= cnt + 6'h01;
                        if (cnt == 6'h0f)
                        begin
                            mdio_oe_n <= 1'b1;
                            mdio_out <= 1'b0;
                            cnt <= 6'h00;
                            state <= ST_PRE;
                        end
                        else if (hit)
                        begin
                            mdio_out <= rd_sh[15];
                            rd_sh <= {rd_sh[14:0], 1'b0};
                        end
                    end
                    ST_WR:
                    begin
                        // data arrives msb first; commit only after the sixteenth bit
                        wr_sh <= {wr_sh[14:0], s_mdio};
                        cnt <= cnt + 6'h01;
                        if (cnt == 6'h0f)
                        begin
                            wr_go <= hit;
                            wr_data <= {wr_sh[14:0], s_mdio};
                            cnt <= 6'h00;
                            state <= ST_PRE;
                        end
                    end
                    default:
                    begin
                        state <= ST_PRE;
                        cnt <= 6'h00;
                    end
                endcase
            end
        end
    end

    // register bits; defaults reload for several cycles so synced straps are valid
    always @(posedge clk)
    begin
        if (rst)
        begin
            init_cnt <= `INIT_CYCLES;
            digital_loopback <= `RST_LOOPBACK;
            speed_select_100 <= `RST_SPEED;
            autoneg_enable <= 1'b0;
            low_power_request <= `RST_POWER_DOWN;
            isolate_bit <= 1'b0;
            autoneg_kick <= 1'b0;
        end
        else
        begin
            autoneg_kick <= 1'b0;
            if (wr_go & wr_data[`BIT_SOFT_RESET])
                init_cnt <= `INIT_CYCLES;
            else if (init_busy)
                init_cnt <= init_cnt - 3'h1;
            if (init_busy)
            begin
                digital_loopback <= `RST_LOOPBACK;
                speed_select_100 <= `RST_SPEED;
                autoneg_enable <= s_an_allowed;
                low_power_request <= `RST_POWER_DOWN;
                isolate_bit <= s_hiz_def;
                if (init_cnt == 3'h1)
                    autoneg_kick <= s_an_allowed;
            end
            // a reset write discards the other bits it carries
            else if (!(wr_go & wr_data[`BIT_SOFT_RESET]))
            begin
                if (wr_go)
                begin
                    digital_loopback <= wr_data[`BIT_LOOPBACK];
                    low_power_request <= wr_data[`BIT_POWER_DOWN];
                    isolate_bit <= wr_data[`BIT_ISOLATE];
                end
                // enable is dropped while not allowed, so a rising strap finds it zero
                if (!s_an_allowed)
                    autoneg_enable <= 1'b0;
                else if (wr_go)
                    autoneg_enable <= wr_data[`BIT_AN_ENABLE];
                // mixed strap codes neither force nor accept the speed bit
                if (autoneg_enable)
                    speed_select_100 <= speed_select_100;
                else if (only_10)
                    speed_select_100 <= 1'b0;
                else if (only_100)
                    speed_select_100 <= 1'b1;
                else if (wr_go & (s_abil == 3'h0))
                    speed_select_100 <= wr_data[`BIT_SPEED];
                if (wr_go & wr_data[`BIT_AN_RESTART] & autoneg_enable)
                    autoneg_kick <= 1'b1;
            end
        end
    end

    // registered effective controls
    always @(posedge clk)
    begin
        if (rst)
        begin
            device_reset <= 1'b1;
            medium_tx_off <= 1'b0;
            medium_rx_off <= 1'b0;
            manual_mode <= 1'b0;
            manual_speed_100 <= 1'b0;
            autoneg_run <= 1'b0;
            low_power <= 1'b0;
            mii_hiz <= 1'b0;
        end
        else
        begin
            device_reset <= init_busy;
            // loop is closed inside the digital core, the medium side stays quiet
            medium_tx_off <= digital_loopback;
            medium_rx_off <= digital_loopback;
            manual_mode <= ~autoneg_enable;
            // speed bit steers nothing while negotiating
            manual_speed_100 <= autoneg_enable ? 1'b0 : speed_select_100;
            autoneg_run <= autoneg_enable;
            // management keeps running in both modes; only the core is affected
            low_power <= low_power_request | s_lp_pin;
            mii_hiz <= isolate_bit | s_iso_pin;
        end
    end
endmodule // phy_basic_control_register
`default_nettype wire

//--- phy_ctrl_asserts.sv
// port assertions for the basic control register
`timescale 1ns/1ns
`default_nettype none
module phy_ctrl_asserts (
    // clock and reset
    input wire clk, rst,
    // management and pins
    input wire mdc, mdio_out, mdio_oe_n, low_power_pin, isolate_pin,
    // control outputs
    input wire device_reset, digital_loopback, medium_tx_off, medium_rx_off,
    input wire manual_mode, manual_speed_100, autoneg_kick, low_power, mii_hiz
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reg mdc_q;
    reg [4:0] n_rise;
    // raw mdc rises seen while the device drives the data pin
    always @(posedge clk)
    begin
        mdc_q <= mdc;
        if (rst || mdio_oe_n)
            n_rise <= 5'h00;
        else if (mdc && !mdc_q)
            n_rise <= n_rise + 5'h01;
    end
    sequence init_hold;
        device_reset [*4];
    endsequence
    sequence soft_end;
        ##[3:8] !device_reset;
    endsequence
    AST_MDIO_IDLE: assert property (mdio_oe_n |-> !mdio_out)
        else $error("data pin not low while released");
    AST_MDIO_LEN: assert property ($rose(mdio_oe_n) |-> n_rise == 5'd17)
        else $error("read drive window not seventeen mdc periods");
    AST_INIT_HOLD: assert property ($fell(rst) |-> init_hold)
        else $error("defaults reload too short after reset");
    AST_SOFT_END: assert property ($rose(device_reset) |-> soft_end)
        else $error("soft reset does not clear");
    AST_LOOP_MEDIUM: assert property (medium_tx_off == $past(digital_loopback)
        && medium_rx_off == medium_tx_off)
        else $error("medium gating does not follow loopback");
    AST_KICK_PULSE: assert property (autoneg_kick |=> !autoneg_kick)
        else $error("restart pulse longer than one cycle");
    AST_SPEED_MANUAL: assert property (manual_speed_100 |-> manual_mode)
        else $error("speed steers while negotiating");
    AST_HIZ_PIN: assert property ((isolate_pin && !device_reset) [*5] |-> mii_hiz)
        else $error("isolate pin ignored");
    AST_LP_PIN: assert property ((low_power_pin && !device_reset) [*5] |-> low_power)
        else $error("power-down pin ignored");
endmodule // phy_ctrl_asserts
bind phy_basic_control_register phy_ctrl_asserts chk_i (.clk(clk), .rst(rst), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .low_power_pin(low_power_pin),
    .isolate_pin(isolate_pin), .device_reset(device_reset),
    .digital_loopback(digital_loopback), .medium_tx_off(medium_tx_off),
    .medium_rx_off(medium_rx_off), .manual_mode(manual_mode),
    .manual_speed_100(manual_speed_100), .autoneg_kick(autoneg_kick),
    .low_power(low_power), .mii_hiz(mii_hiz));
`default_nettype wire

//--- phy_ctrl_defines.vh
// constants for the basic control register and its management frame
// How it works
// - writing one to bit 15 reloads every default, then the bit clears itself
// - loopback set blocks medium transmit and ignores medium receive data
// - loopback returns data deep inside the digital path, not at the pins
// - speed bit one means 100 Mb/s, zero 10 Mb/s, reset value one
// - speed bit writable only with straps all zero and negotiation off
// - negotiation off: 10-only straps force zero, 100-only force one, writes ignored
// - negotiation on: speed bit ignores writes and steers nothing
// - straps going to zero leave the speed bit as it was until written
// - negotiation enable settable only with allowed strap high, defaults to the allowed strap
// - negotiation off: speed comes from the speed bit or the straps
// - allowed strap rising without reset leaves enable zero until written one
// - power-down bit enters low power, management still answers
// - power-down pin high enters the same low power state
// - isolate bit floats the MII outputs, management still answers
// - isolate reset value follows the hiz default strap
// - isolate pin also isolates, independent of the bit
// - writing one to restart bit restarts negotiation, bit clears itself
// - negotiation starts by itself after power-up or reset
// - 16-bit register reached over the serial management data and clock pins
`ifndef PHY_CTRL_DEFINES_VH
`define PHY_CTRL_DEFINES_VH
`define CTRL_REG_ADDR 5'h00
`define BCAST_PHY_ADDR 5'h00
`define BIT_SOFT_RESET 15
`define BIT_LOOPBACK 14
`define BIT_SPEED 13
`define BIT_AN_ENABLE 12
`define BIT_POWER_DOWN 11
`define BIT_ISOLATE 10
`define BIT_AN_RESTART 9
`define RST_LOOPBACK 1'b0
`define RST_SPEED 1'b1
`define RST_POWER_DOWN 1'b0
`define INIT_CYCLES 3'h4
`define PREAMBLE_ONES 6'h20
`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define ABIL_10 0
`define ABIL_100 1
`endif

//--- tb_phy_basic_control_register.sv
// self-checking bench for the basic control register
`timescale 1ns/1ns
`default_nettype none
`include "phy_ctrl_defines.vh"
module tb_phy_basic_control_register;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [4:0] phy_address = 5'h01;
    reg [2:0] ability_straps = 3'b000;
    reg autoneg_allowed_strap = 1'b1;
    reg hiz_default_strap = 1'b1;
    reg low_power_pin = 1'b0;
    reg isolate_pin = 1'b0;
    wire mdc, mdio_in, mdio_out, mdio_oe_n, device_reset, digital_loopback;
    wire medium_tx_off, medium_rx_off, manual_mode, manual_speed_100;
    wire autoneg_run, autoneg_kick, low_power, mii_hiz;
    integer errors = 0;
    integer n_checks = 0;
    reg [15:0] kicks = 16'h0000;
    integer cycles = 0;
    integer seed = 53;
    reg [31:0] r;
    reg [15:0] exp_q[$];
    reg [15:0] rd_val;
    reg [15:0] junk;
    event rd_done;
    always #5 clk = ~clk;
    phy_basic_control_register dut (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_address(phy_address),
        .ability_straps(ability_straps), .autoneg_allowed_strap(autoneg_allowed_strap),
        .hiz_default_strap(hiz_default_strap), .low_power_pin(low_power_pin),
        .isolate_pin(isolate_pin), .device_reset(device_reset),
        .digital_loopback(digital_loopback), .medium_tx_off(medium_tx_off),
        .medium_rx_off(medium_rx_off), .manual_mode(manual_mode),
        .manual_speed_100(manual_speed_100), .autoneg_run(autoneg_run),
        .autoneg_kick(autoneg_kick), .low_power(low_power), .mii_hiz(mii_hiz));
    mdio_master m (.mdio_oe_n(mdio_oe_n), .mdio_out(mdio_out), .mdc(mdc), .mdio(mdio_in));
    task automatic chk(input [127:0] what, input [15:0] e, input [15:0] s);
    begin
        n_checks = n_checks + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("BAD %0s exp %h got %h", what, e, s);
        end
    end
    endtask
    task automatic chk_bit(input [127:0] what, input e, input s);
    begin
        n_checks = n_checks + 1;
        if (s !== e)
        begin
            errors = errors + 1;
            $display("BAD %0s exp %b got %b", what, e, s);
        end
    end
    endtask
    task conclude;
    begin
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    // writes leave time for the commit to cross back into clk
    task automatic wr(input [15:0] d);
        reg [15:0] q;
    begin
        m.xfer(`OP_WRITE, phy_address, `CTRL_REG_ADDR, d, q);
        repeat (10) @(posedge clk);
    end
    endtask
    task automatic rd(input [4:0] pa, input [4:0] ra, input [15:0] e);
    begin
        exp_q.push_back(e);
        m.xfer(`OP_READ, pa, ra, 16'h0000, rd_val);
        -> rd_done;
    end
    endtask
    always @(rd_done) chk("read", exp_q.pop_front(), rd_val);
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (autoneg_kick === 1'b1) kicks = kicks + 16'h0001;
        if (cycles == 60000)
        begin
            errors = errors + 1;
            conclude;
        end
    end
    initial
    begin
        r = $random(seed);
        phy_address <= {1'b0, r[3:1], 1'b1};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        chk("kicks", 16'h0001, kicks);
        rd(phy_address, 5'h00, 16'h3400);
        chk_bit("an_run", 1'b1, autoneg_run);
        rd(phy_address ^ 5'h10, 5'h00, 16'hffff);
        rd(`BCAST_PHY_ADDR, 5'h01, 16'hffff);
        wr(16'h1000);
        rd(`BCAST_PHY_ADDR, 5'h00, 16'h3000);
        chk_bit("speed", 1'b0, manual_speed_100);
        wr(16'h1200);
        chk("kicks", 16'h0002, kicks);
        rd(phy_address, 5'h00, 16'h3000);
        wr(16'h2000);
        wr(16'h0000);
        rd(phy_address, 5'h00, 16'h0000);
        chk_bit("manual", 1'b1, manual_mode);
        chk_bit("an_run", 1'b0, autoneg_run);
        wr(16'h0200);
        chk("kicks", 16'h0002, kicks);
        wr(16'h2000);
        chk_bit("speed", 1'b1, manual_speed_100);
        ability_straps <= 3'b001;
        rd(phy_address, 5'h00, 16'h0000);
        wr(16'h2000);
        rd(phy_address, 5'h00, 16'h0000);
        ability_straps <= 3'b010;
        rd(phy_address, 5'h00, 16'h2000);
        ability_straps <= 3'b000;
        rd(phy_address, 5'h00, 16'h2000);
        wr(16'h4800);
        chk_bit("loop", 1'b1, digital_loopback);
        chk_bit("tx_off", 1'b1, medium_tx_off);
        chk_bit("rx_off", 1'b1, medium_rx_off);
        chk_bit("low_power", 1'b1, low_power);
        rd(phy_address, 5'h00, 16'h4800);
        wr(16'h0400);
        chk_bit("hiz", 1'b1, mii_hiz);
        rd(phy_address, 5'h00, 16'h0400);
        wr(16'h0000);
        chk_bit("tx_off", 1'b0, medium_tx_off);
        low_power_pin <= 1'b1;
        isolate_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk_bit("low_power", 1'b1, low_power);
        chk_bit("hiz", 1'b1, mii_hiz);
        low_power_pin <= 1'b0;
        isolate_pin <= 1'b0;
        autoneg_allowed_strap <= 1'b0;
        wr(16'h1000);
        rd(phy_address, 5'h00, 16'h0000);
        chk_bit("low_power", 1'b0, low_power);
        chk_bit("hiz", 1'b0, mii_hiz);
        autoneg_allowed_strap <= 1'b1;
        rd(phy_address, 5'h00, 16'h0000);
        wr(16'h1000);
        rd(phy_address, 5'h00, 16'h1000);
        m.xfer(2'b11, phy_address, `CTRL_REG_ADDR, 16'hffff, junk);
        chk("bad_op", 16'hffff, junk);
        rd(phy_address, 5'h00, 16'h1000);
        hiz_default_strap <= 1'b0;
        wr(16'h8000);
        chk("kicks", 16'h0003, kicks);
        rd(phy_address, 5'h00, 16'h3000);
        conclude;
    end
endmodule // tb_phy_basic_control_register
`default_nettype wire
